// ===== src/ods_pkg.sv
package ods_pkg;
	// register addresses on page 1
	localparam logic [7:0] ODS_SPK_CTRL_ADDR  = 8'h20;
	localparam logic [7:0] ODS_POP_RMV_ADDR   = 8'h21;
	localparam logic [7:0] ODS_RAMP_WAIT_ADDR = 8'h22;
	// field positions
	localparam int ODS_SPK_PWR_BIT   = 7;
	localparam int ODS_SPK_SHORT_BIT = 0;
	localparam int ODS_PD_ORDER_BIT  = 7;
	localparam int ODS_PON_LSB       = 3;
	localparam int ODS_STEP_LSB      = 1;
	localparam int ODS_CM_BIT        = 0;
	localparam int ODS_WAIT_LSB      = 4;
	// reset values
	localparam logic [7:0] ODS_SPK_CTRL_RST  = 8'h06;
	localparam logic [7:0] ODS_POP_RMV_RST   = 8'h3e;
	localparam logic [7:0] ODS_RAMP_WAIT_RST = 8'h00;
	// writable masks; reserved bits keep their reset value
	localparam logic [7:0] ODS_SPK_CTRL_WMASK  = 8'h80;
	localparam logic [7:0] ODS_POP_RMV_WMASK   = 8'hfe;
	localparam logic [7:0] ODS_RAMP_WAIT_WMASK = 8'h70;
	// timers count internal oscillator ticks at nominal 8.2 MHz
	localparam real ODS_OSC_MHZ = 8.2;
	// driver power-on times in microseconds, codes 0..11
	localparam real ODS_PON_US [12] = '{0.0, 15.3, 15.3, 1530.0, 15300.0, 76200.0,
		153000.0, 304000.0, 610000.0, 1220000.0, 3040000.0, 6100000.0};
	// ramp-up step times in microseconds
	localparam real ODS_STEP_US [4] = '{0.0, 980.0, 1950.0, 3900.0};
	// speaker power-up wait times in microseconds
	localparam real ODS_WAIT_US [8] = '{0.0, 3040.0, 7620.0, 12200.0, 15300.0,
		19800.0, 24400.0, 30500.0};
	localparam int ODS_TMR_W = 26;
	typedef enum logic [2:0] {ODS_OFF, ODS_PWR_ON, ODS_RAMP, ODS_SPK_WAIT, ODS_ON,
		ODS_AMP_DOWN, ODS_DAC_DOWN} ods_state_t;
endpackage

// ===== src/ods_sequencer.sv
// How it works
// - speaker control bit 7 powers the speaker driver up or down; resets low
// - speaker control bit 0 reads live short status while speaker control bit 7 is high
// - live short bit is not latched; a sticky flag lives elsewhere
// - ordering bit low: DAC powers down together with amplifiers
// - ordering bit high: DAC powers down after amplifiers are fully down
// - bits 6-3 choose driver power-on time, reset code 0111 (304 ms)
// - bits 2-1 choose ramp step 0/0.98/1.95/3.9 ms, reset 11
// - all durations count the internal oscillator, nominal 8.2 MHz
// - bits 6-4 of register 0x22 choose speaker wait time, reset 000
// - pop-removal bit 0 stays zero, selecting the weak divider common mode
`timescale 1ns/1ns
module ods_sequencer
	import ods_pkg::*;
#(
	parameter int RAMP_STEPS = 4
)(
	// clock, reset, enable
	input  wire logic       core_clk_in,
	input  wire logic       nrst_in,
	input  wire logic       clk_en_in,
	// internal oscillator tick, one pulse per oscillator cycle (same domain)
	input  wire logic       osc_tick_in,
	// register port
	input  wire logic [7:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	// software power-down request (pulse)
	input  wire logic       pd_req_in,
	// analog status pin
	input  wire logic       spk_short_in,
	// analog controls
	output logic            spk_amp_en_out,
	output logic            hp_amp_en_out,
	output logic            dac_en_out,
	output logic            ramp_step_out,
	output logic            busy_out
);
	// step counter is six bits wide
	if (RAMP_STEPS < 1 || RAMP_STEPS > 64) begin : g_bad_steps
		$error("RAMP_STEPS out of range");
	end

	function automatic logic [ODS_TMR_W-1:0] cyc(input real us);
		return ODS_TMR_W'($rtoi(us * ODS_OSC_MHZ));
	endfunction

	logic [7:0] spk_ctrl_reg;
	logic [7:0] pop_rmv_reg;
	logic [7:0] ramp_wait_reg;
	logic       short_s1_reg;
	logic       short_s2_reg;
	logic       pd_pending_reg;
	ods_state_t state_reg;
	logic [ODS_TMR_W-1:0] tmr_reg;
	logic [ODS_TMR_W-1:0] tmr_end;
	logic [5:0] step_cnt_reg;
	logic       spk_on;

	assign spk_on = spk_ctrl_reg[ODS_SPK_PWR_BIT];

	// register writes: only documented fields change
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			spk_ctrl_reg  <= ODS_SPK_CTRL_RST;
			pop_rmv_reg   <= ODS_POP_RMV_RST;
			ramp_wait_reg <= ODS_RAMP_WAIT_RST;
		end else if (clk_en_in && reg_wr_in) begin
			unique case (reg_addr_in)
				ODS_SPK_CTRL_ADDR: spk_ctrl_reg <= (reg_wdata_in & ODS_SPK_CTRL_WMASK) |
					(ODS_SPK_CTRL_RST & ~ODS_SPK_CTRL_WMASK);
				ODS_POP_RMV_ADDR: pop_rmv_reg <= (reg_wdata_in & ODS_POP_RMV_WMASK) |
					(ODS_POP_RMV_RST & ~ODS_POP_RMV_WMASK);
				ODS_RAMP_WAIT_ADDR: ramp_wait_reg <= (reg_wdata_in & ODS_RAMP_WAIT_WMASK) |
					(ODS_RAMP_WAIT_RST & ~ODS_RAMP_WAIT_WMASK);
				default: ;
			endcase
		end
	end

	// short status comes from the analog domain
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			short_s1_reg <= 1'b0;
			short_s2_reg <= 1'b0;
		end else if (clk_en_in) begin
			short_s1_reg <= spk_short_in;
			short_s2_reg <= short_s1_reg;
		end
	end

	// read mux registered so the data port comes from a flip-flop
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (clk_en_in) begin
			unique case (reg_addr_in)
				ODS_SPK_CTRL_ADDR: reg_rdata_out <= {spk_ctrl_reg[7:1],
					short_s2_reg & spk_on};
				ODS_POP_RMV_ADDR:   reg_rdata_out <= pop_rmv_reg;
				ODS_RAMP_WAIT_ADDR: reg_rdata_out <= ramp_wait_reg;
				default:            reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// power-down request held until software drops the speaker bit; releasing it
	// earlier would power the driver straight back up after a software power-down
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			pd_pending_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (pd_req_in)
				pd_pending_reg <= 1'b1;
			else if (state_reg == ODS_OFF && !spk_on)
				pd_pending_reg <= 1'b0;
		end
	end

	// terminal count for the current phase
	always_comb begin
		logic [3:0] pon;
		pon = pop_rmv_reg[ODS_PON_LSB +: 4];
		tmr_end = '0;
		unique case (state_reg)
			ODS_PWR_ON: tmr_end = (pon < 4'd12) ? cyc(ODS_PON_US[pon]) : '0;
			ODS_RAMP:   tmr_end = cyc(ODS_STEP_US[pop_rmv_reg[ODS_STEP_LSB +: 2]]);
			ODS_SPK_WAIT: tmr_end = cyc(ODS_WAIT_US[ramp_wait_reg[ODS_WAIT_LSB +: 3]]);
			ODS_AMP_DOWN: tmr_end = cyc(ODS_STEP_US[pop_rmv_reg[ODS_STEP_LSB +: 2]]);
			default:    tmr_end = '0;
		endcase
	end

	// sequencer; the timer clears on every state change
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			state_reg     <= ODS_OFF;
			tmr_reg       <= '0;
			step_cnt_reg  <= '0;
			ramp_step_out <= 1'b0;
		end else if (clk_en_in) begin
			ramp_step_out <= 1'b0;
			if (osc_tick_in && tmr_reg < tmr_end)
				tmr_reg <= tmr_reg + 1'b1;
			unique case (state_reg)
				ODS_OFF: if (spk_on && !pd_pending_reg) begin
					state_reg <= ODS_PWR_ON;
					tmr_reg   <= '0;
				end
				ODS_PWR_ON: if (tmr_reg >= tmr_end) begin
					state_reg    <= ODS_RAMP;
					step_cnt_reg <= '0;
					tmr_reg      <= '0;
				end
				ODS_RAMP: if (tmr_reg >= tmr_end) begin
					ramp_step_out <= 1'b1;
					tmr_reg       <= '0;
					if (step_cnt_reg == 6'(RAMP_STEPS - 1))
						state_reg <= ODS_SPK_WAIT;
					else
						step_cnt_reg <= step_cnt_reg + 1'b1;
				end
				ODS_SPK_WAIT: if (tmr_reg >= tmr_end) begin
					state_reg <= ODS_ON;
					tmr_reg   <= '0;
				end
				ODS_ON: if (pd_pending_reg || !spk_on) begin
					state_reg <= ODS_AMP_DOWN;
					tmr_reg   <= '0;
				end
				ODS_AMP_DOWN: if (tmr_reg >= tmr_end) begin
					state_reg <= pop_rmv_reg[ODS_PD_ORDER_BIT] ? ODS_DAC_DOWN : ODS_OFF;
					tmr_reg   <= '0;
				end
				ODS_DAC_DOWN: state_reg <= ODS_OFF;
				default: state_reg <= ODS_OFF;
			endcase
		end
	end

	// analog enables
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			spk_amp_en_out <= 1'b0;
			hp_amp_en_out  <= 1'b0;
			dac_en_out     <= 1'b0;
			busy_out       <= 1'b0;
		end else if (clk_en_in) begin
			spk_amp_en_out <= spk_on && (state_reg inside {ODS_PWR_ON, ODS_RAMP,
				ODS_SPK_WAIT, ODS_ON});
			hp_amp_en_out  <= state_reg inside {ODS_PWR_ON, ODS_RAMP, ODS_SPK_WAIT, ODS_ON};
			// ordering bit low drops the DAC with the amps; high keeps it through ramp-down
			dac_en_out     <= (state_reg != ODS_OFF) && (state_reg != ODS_DAC_DOWN) &&
				!(state_reg == ODS_AMP_DOWN && !pop_rmv_reg[ODS_PD_ORDER_BIT]);
			busy_out       <= state_reg != ODS_OFF && state_reg != ODS_ON;
		end
	end

	// checks
	sequence s_amp_down_done;
		state_reg == ODS_AMP_DOWN && tmr_reg >= tmr_end && clk_en_in;
	endsequence

	a_spk_pwr_reset: assert property (@(posedge core_clk_in)
		!nrst_in |=> !spk_ctrl_reg[ODS_SPK_PWR_BIT] && !spk_amp_en_out)
		else $error("speaker power not cleared by reset");
	a_short_gated: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && reg_addr_in == ODS_SPK_CTRL_ADDR && !spk_on |=> !reg_rdata_out[0])
		else $error("short status shown while speaker is down");
	a_short_live: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && reg_addr_in == ODS_SPK_CTRL_ADDR |=>
		reg_rdata_out[0] == ($past(short_s2_reg) && $past(spk_on)))
		else $error("short status does not follow the live level");
	a_dac_with_amps: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && state_reg == ODS_AMP_DOWN && !pop_rmv_reg[ODS_PD_ORDER_BIT]
		|=> !dac_en_out)
		else $error("dac not dropped together with amplifiers");
	a_dac_after_amps: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		s_amp_down_done ##0 pop_rmv_reg[ODS_PD_ORDER_BIT] |=>
		dac_en_out && !hp_amp_en_out ##1 !dac_en_out)
		else $error("dac dropped before amplifiers were down");
	a_pon_reset: assert property (@(posedge core_clk_in)
		!nrst_in |=> pop_rmv_reg[ODS_PON_LSB +: 4] == 4'h7)
		else $error("power-on field reset wrong");
	a_step_reset: assert property (@(posedge core_clk_in)
		!nrst_in |=> pop_rmv_reg[ODS_STEP_LSB +: 2] == 2'h3)
		else $error("ramp step field reset wrong");
	a_cm_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!pop_rmv_reg[ODS_CM_BIT])
		else $error("common mode bit set");
	a_wait_reset: assert property (@(posedge core_clk_in)
		!nrst_in |=> ramp_wait_reg[ODS_WAIT_LSB +: 3] == 3'h0)
		else $error("wait field reset wrong");
	a_timer_restart: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && $changed(state_reg) |-> tmr_reg == '0)
		else $error("timer not restarted on transition");
	a_timer_bound: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && !osc_tick_in && $stable(state_reg) && tmr_reg < tmr_end |=>
		$stable(tmr_reg) || $changed(state_reg))
		else $error("timer advanced without oscillator tick");

	sequence s_power_up_start;
		clk_en_in && state_reg == ODS_OFF && spk_on && !pd_pending_reg;
	endsequence
	sequence s_ramp_done;
		clk_en_in && state_reg == ODS_RAMP && tmr_reg >= tmr_end;
	endsequence

	a_power_up_start: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		s_power_up_start |=> state_reg == ODS_PWR_ON ##1 hp_amp_en_out && dac_en_out)
		else $error("enables did not rise after power-up start");
	a_spk_bit_low: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && !spk_on |=> !spk_amp_en_out)
		else $error("speaker amp enabled while its bit is low");
	a_short_sync: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in |=> short_s2_reg == $past(short_s1_reg))
		else $error("short synchroniser skipped a stage");
	a_pon_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && state_reg == ODS_PWR_ON && tmr_reg < tmr_end |=> state_reg == ODS_PWR_ON)
		else $error("power-on phase ended early");
	a_pon_clamp: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		state_reg == ODS_PWR_ON && pop_rmv_reg[ODS_PON_LSB +: 4] >= 4'hc |-> tmr_end == '0)
		else $error("reserved power-on code not treated as zero");
	a_ramp_pulse: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		s_ramp_done |=> ramp_step_out)
		else $error("ramp step not pulsed");
	a_ramp_source: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ramp_step_out |-> $past(state_reg) == ODS_RAMP)
		else $error("ramp step pulsed outside the ramp");
	a_ramp_last: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		s_ramp_done ##0 step_cnt_reg == 6'(RAMP_STEPS - 1) |=> state_reg == ODS_SPK_WAIT)
		else $error("ramp did not end after the last step");
	a_wait_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && state_reg == ODS_SPK_WAIT && tmr_reg < tmr_end |=> state_reg == ODS_SPK_WAIT)
		else $error("speaker wait ended early");
	a_amps_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && state_reg == ODS_AMP_DOWN |=> !hp_amp_en_out && !spk_amp_en_out)
		else $error("amplifiers still enabled during power-down");
	a_dac_last: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && state_reg == ODS_DAC_DOWN |=> !dac_en_out && state_reg == ODS_OFF)
		else $error("dac not dropped at the end of power-down");
	a_reserved_kept: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		spk_ctrl_reg[6:1] == ODS_SPK_CTRL_RST[6:1] && ramp_wait_reg[3:0] == 4'h0)
		else $error("reserved bits changed");
	a_timer_tick: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && osc_tick_in && tmr_reg < tmr_end &&
		state_reg inside {ODS_PWR_ON, ODS_RAMP, ODS_SPK_WAIT, ODS_AMP_DOWN} |=>
		tmr_reg == $past(tmr_reg) + 1'b1)
		else $error("timer missed an oscillator tick");

	// clock enable and handshake bookkeeping
	a_freeze_state: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!clk_en_in |=> $stable(state_reg) && $stable(tmr_reg) && $stable(spk_ctrl_reg))
		else $error("state moved while clock enable low");
	a_busy_idle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && state_reg == ODS_OFF |=> !busy_out)
		else $error("busy while idle");
	a_pd_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && pd_req_in |=> pd_pending_reg)
		else $error("power-down request lost");
endmodule

// ===== verif/ods_host_model.sv
`timescale 1ns/1ns
module ods_host_model
	import ods_pkg::*;
(
	// clock and read-back
	input  wire logic       core_clk_in,
	input  wire logic [7:0] reg_rdata_in,
	// register port toward the block
	output logic      [7:0] reg_addr_out,
	output logic            reg_wr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            pd_req_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
		pd_req_out = 1'b0;
	end
	// a real host keeps reserved bits at reset value, so the model does too
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] val);
		logic [7:0] d;
		d = val;
		if (addr == ODS_SPK_CTRL_ADDR)
			d = (val & ODS_SPK_CTRL_WMASK) | (ODS_SPK_CTRL_RST & ~ODS_SPK_CTRL_WMASK);
		if (addr == ODS_POP_RMV_ADDR) begin
			d[ODS_CM_BIT] = 1'b0;
			if (d[6:3] >= 4'hc)
				d[6:3] = 4'h0;
		end
		if (addr == ODS_RAMP_WAIT_ADDR)
			d = val & ODS_RAMP_WAIT_WMASK;
		@(posedge core_clk_in);
		reg_addr_out <= addr;
		reg_wr_out <= 1'b1;
		reg_wdata_out <= d;
		@(posedge core_clk_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge core_clk_in);
		reg_addr_out <= addr;
		@(posedge core_clk_in);
		// registered read data settles after the edge that takes the address
		@(negedge core_clk_in);
		data = reg_rdata_in;
	endtask
	task automatic pulse_pd();
		@(posedge core_clk_in);
		pd_req_out <= 1'b1;
		@(posedge core_clk_in);
		pd_req_out <= 1'b0;
	endtask
endmodule

// ===== verif/ods_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module output_driver_power_sequencing_tb_top;
	import ods_pkg::*;
	logic       core_clk_in, nrst_in, osc_tick_in, spk_short_in;
	logic       pd_req, reg_wr, spk_en, hp_en, dac_en, busy, clk_en, ramp_step;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
	int         mismatches, compares, n, ticks, steps;
	ods_sequencer #(.RAMP_STEPS(1)) dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
		.clk_en_in(clk_en), .osc_tick_in(osc_tick_in), .reg_addr_in(reg_addr),
		.reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
		.pd_req_in(pd_req), .spk_short_in(spk_short_in), .spk_amp_en_out(spk_en),
		.hp_amp_en_out(hp_en), .dac_en_out(dac_en), .ramp_step_out(ramp_step),
		.busy_out(busy));
	ods_host_model host (.core_clk_in(core_clk_in), .reg_rdata_in(reg_rdata),
		.reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata),
		.pd_req_out(pd_req));
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	// oscillator tick every other cycle keeps the timed phases short
	always @(posedge core_clk_in) osc_tick_in <= ~osc_tick_in;
	always @(posedge core_clk_in) if (ramp_step === 1'b1) steps++;
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic power_up(input logic [7:0] pop);
		host.write_reg(ODS_POP_RMV_ADDR, pop);
		host.write_reg(ODS_SPK_CTRL_ADDR, 8'h06);
		steps = 0;
		host.write_reg(ODS_SPK_CTRL_ADDR, 8'h86);
		// sample away from the edge so registered outputs have settled
		repeat (3) @(negedge core_clk_in);
		ticks = 0;
		n = 0;
		while (busy !== 1'b0 && n < 40000) begin
			@(negedge core_clk_in);
			ticks += osc_tick_in;
			n++;
		end
		`CHK("busy_done", 1'b0, busy)
		`CHK("spk_en", 1'b1, spk_en)
		`CHK("dac_en", 1'b1, dac_en)
		`CHK("ramp_steps", 1, steps)
	endtask
	task automatic wait_amps_off();
		n = 0;
		while (hp_en !== 1'b0 && n < 20000) begin
			@(negedge core_clk_in);
			n++;
		end
		`CHK("hp_off", 1'b0, hp_en)
	endtask
	task automatic t_freeze();
		@(posedge core_clk_in);
		clk_en <= 1'b0;
		host.write_reg(ODS_RAMP_WAIT_ADDR, 8'h70);
		clk_en <= 1'b1;
		host.read_reg(ODS_RAMP_WAIT_ADDR, rd);
		`CHK("frozen_write", 8'h00, rd)
		host.write_reg(ODS_RAMP_WAIT_ADDR, 8'h70);
		host.read_reg(ODS_RAMP_WAIT_ADDR, rd);
		`CHK("wait_field", 8'h70, rd)
		host.write_reg(ODS_RAMP_WAIT_ADDR, 8'h00);
	endtask
	task automatic t_reset_values();
		host.read_reg(ODS_SPK_CTRL_ADDR, rd);
		`CHK("spk_ctrl", 8'h06, rd)
		host.read_reg(ODS_POP_RMV_ADDR, rd);
		`CHK("pop_rmv", 8'h3e, rd)
		host.read_reg(ODS_RAMP_WAIT_ADDR, rd);
		`CHK("ramp_wait", 8'h00, rd)
		host.read_reg(8'h23, rd);
		`CHK("unmapped", 8'h00, rd)
	endtask
	task automatic t_step_timing();
		// power-on code 0, step code 01 (0.98 ms = 8036 ticks), order bit low
		power_up(8'h02);
		`CHK("step_ticks", 1'b1, (ticks >= 8035 && ticks <= 8040))
	endtask
	task automatic t_short_live();
		spk_short_in <= 1'b1;
		host.read_reg(ODS_SPK_CTRL_ADDR, rd);
		host.read_reg(ODS_SPK_CTRL_ADDR, rd);
		`CHK("short_on", 8'h87, rd)
		spk_short_in <= 1'b0;
		host.read_reg(ODS_SPK_CTRL_ADDR, rd);
		host.read_reg(ODS_SPK_CTRL_ADDR, rd);
		`CHK("short_off", 8'h86, rd)
	endtask
	task automatic t_down_together();
		host.write_reg(ODS_SPK_CTRL_ADDR, 8'h06);
		wait_amps_off();
		`CHK("spk_off", 1'b0, spk_en)
		`CHK("dac_with_amps", 1'b0, dac_en)
	endtask
	task automatic t_down_ordered();
		power_up(8'h80);
		`CHK("restart_ticks", 1'b1, (ticks <= 4))
		host.pulse_pd();
		wait_amps_off();
		`CHK("dac_after_amps", 1'b1, dac_en)
		repeat (4) @(negedge core_clk_in);
		`CHK("dac_late_off", 1'b0, dac_en)
	endtask
	initial begin
		nrst_in = 1'b0;
		osc_tick_in = 1'b0;
		spk_short_in = 1'b0;
		clk_en = 1'b1;
		repeat (12) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		t_reset_values();
		t_freeze();
		t_step_timing();
		t_short_live();
		t_down_together();
		t_down_ordered();
		tally_and_finish();
	end
	initial begin
		#(8 * 60000);
		mismatches++;
		tally_and_finish();
	end
endmodule
